// ==== src/vib_top.sv ====
// Interface adapter: processor bus, sixteen-register decode, two ports, control lines.
// Assumes every pin is synchronous to clk_i and phi2_i is far slower than clk_i.
//
// Notes on behaviour
// R1 - Reset pin clears all registers except timer counters, latches and shift register.
// R2 - While reset pin is low, every port line is an input.
// R3 - During reset timers, shift register and interrupt logic stay inactive.
// R4 - Selected read drives the chosen register; selected write stores bus data.
// R5 - Data bus is released whenever the chip is not selected.
// R6 - Processor raises high select, lowers low select before the access.
// R7 - Four select inputs choose one of sixteen registers.
// R8 - Register map as listed; register 15 is port A without handshake.
// R9 - Interrupt line pulls low while any flag and its enable are both set.
// R10 - Interrupt output is open drain for wired sharing.
// R11 - Direction bit zero makes an input, one makes an output, per line.
// R12 - Output lines follow their stored output bit.
// R13 - Stored bits of input lines never reach the pins.
// R14 - Port A input may be latched by the first A control line.
// R15 - Each of four control lines sets its own flag with own enable.
// R16 - Timer one may drive port B bit 7; timer two counts bit 6 pulses.
// R17 - Port B control lines act as serial clock and data.
// R18 - External serial clock holds each level at least two cycles.
// R19 - Counted bit 6 pulses are spaced at least two cycles.
// R20 - Pulse mode drops A second control line for one phase cycle after A read.
// R21 - Port B reads output bits for output lines; port A reads pins.
// R22 - Read data driven while phase two is high; writes taken at its fall.
`timescale 1ns/10ps
`include "vib_cfg.svh"

module vib_top
  import vib_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reset_in_n_i,
  // Processor bus
  input wire logic phi2_i,
  input wire vib_bus_t bus_i,
  output logic [`VIB_DW-1:0] data_o,
  output logic data_oe_o,
  output logic irq_o,
  output logic irq_oe_o,
  // Port A
  input wire logic [`VIB_DW-1:0] port_a_lines_i,
  output logic [`VIB_DW-1:0] port_a_lines_o,
  output logic [`VIB_DW-1:0] port_a_lines_oe_o,
  input wire logic port_a_control_one_i,
  input wire logic port_a_control_two_i,
  output logic port_a_control_two_o,
  output logic port_a_control_two_oe_o,
  // Port B
  input wire logic [`VIB_DW-1:0] port_b_lines_i,
  output logic [`VIB_DW-1:0] port_b_lines_o,
  output logic [`VIB_DW-1:0] port_b_lines_oe_o,
  input wire logic port_b_control_one_i,
  input wire logic port_b_control_two_i,
  output logic port_b_control_two_o,
  output logic port_b_control_two_oe_o
);

  vib_state_t s_q;
  vib_state_t s_d;

  logic pin_rst;
  logic sel;
  logic tick;
  logic rd;
  logic wr;
  logic [3:0] rs;
  logic [`VIB_DW-1:0] wd;
  logic ca1_edge;
  logic ca2_edge;
  logic cb1_edge;
  logic cb2_edge;
  logic cb1_rise;
  logic cb1_fall;
  logic pb6_fall;
  logic irq_any;
  logic [2:0] ca2_mode;
  logic [2:0] cb2_mode;
  logic [2:0] sr_mode;
  logic [`VIB_DW-1:0] pa_rdata;
  logic [`VIB_DW-1:0] pb_rdata;
  logic [`VIB_DW-1:0] pa_dir;
  logic [`VIB_DW-1:0] pb_dir;
  logic [`VIB_DW-1:0] rmux;
  logic [`VIB_FLAGS-1:0] f_set;
  logic [`VIB_FLAGS-1:0] f_clr;

  // ****************************************
  // Bus decode
  // ****************************************
  assign pin_rst = ~reset_in_n_i;
  assign sel = bus_i.sel_high & ~bus_i.sel_low_n; // R6
  // Side effects act once per access, at the falling edge of phase two.
  assign tick = s_q.phi2_p & ~phi2_i; // R22
  assign rd = sel & tick & bus_i.rw & ~pin_rst; // R4
  assign wr = sel & tick & ~bus_i.rw & ~pin_rst; // R4
  assign rs = bus_i.register_select; // R7
  assign wd = bus_i.wdata;

  assign ca2_mode = s_q.control_line_config[`VIB_PCR_CA2_HI:`VIB_PCR_CA2_LO];
  assign cb2_mode = s_q.control_line_config[`VIB_PCR_CB2_HI:`VIB_PCR_CB2_LO];
  assign sr_mode = s_q.auxiliary_control[`VIB_ACR_SR_HI:`VIB_ACR_SR_LO];

  // ****************************************
  // Control line edges
  // ****************************************
  assign ca1_edge = s_q.control_line_config[`VIB_PCR_CA1_POS] ? (~s_q.ca1_p & port_a_control_one_i)
                                               : (s_q.ca1_p & ~port_a_control_one_i);
  assign ca2_edge = s_q.control_line_config[`VIB_PCR_CA2_LO] ? (~s_q.ca2_p & port_a_control_two_i)
                                              : (s_q.ca2_p & ~port_a_control_two_i);
  assign cb1_edge = s_q.control_line_config[`VIB_PCR_CB1_POS] ? (~s_q.cb1_p & port_b_control_one_i)
                                               : (s_q.cb1_p & ~port_b_control_one_i);
  assign cb2_edge = s_q.control_line_config[`VIB_PCR_CB2_LO] ? (~s_q.cb2_p & port_b_control_two_i)
                                              : (s_q.cb2_p & ~port_b_control_two_i);
  // Single-sample edge detection relies on the far side holding each level.
  assign cb1_rise = ~s_q.cb1_p & port_b_control_one_i; // R18
  assign cb1_fall = s_q.cb1_p & ~port_b_control_one_i; // R18
  assign pb6_fall = s_q.pb6_p & ~port_b_lines_i[`VIB_PB_CNT]; // R19

  assign irq_any = |(s_q.interrupt_flags & s_q.interrupt_enables); // R9

  // ****************************************
  // Ports
  // ****************************************
  vib_port #(
    .W(`VIB_DW),
    .OUT_READBACK(1'b0)
  ) u_port_a (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(pin_rst),
    .wr_data_i(wr && (rs == `VIB_REG_PA || rs == `VIB_REG_PA_NH)),
    .wr_dir_i(wr && rs == `VIB_REG_DIRA),
    .wdata_i(wd),
    .read_ack_i(rd && (rs == `VIB_REG_PA || rs == `VIB_REG_PA_NH)),
    .rdata_o(pa_rdata),
    .dir_o(pa_dir),
    .latch_en_i(s_q.auxiliary_control[`VIB_ACR_PA_LATCH]),
    .latch_stb_i(ca1_edge), // R14
    .ovr_en_i(1'b0),
    .ovr_val_i(1'b0),
    .pins_i(port_a_lines_i),
    .pins_o(port_a_lines_o),
    .pins_oe_o(port_a_lines_oe_o)
  );

  vib_port #(
    .W(`VIB_DW),
    .OUT_READBACK(1'b1)
  ) u_port_b (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(pin_rst),
    .wr_data_i(wr && rs == `VIB_REG_PB),
    .wr_dir_i(wr && rs == `VIB_REG_DIRB),
    .wdata_i(wd),
    .read_ack_i(rd && rs == `VIB_REG_PB),
    .rdata_o(pb_rdata),
    .dir_o(pb_dir),
    .latch_en_i(s_q.auxiliary_control[`VIB_ACR_PB_LATCH]),
    .latch_stb_i(cb1_edge),
    .ovr_en_i(s_q.auxiliary_control[`VIB_ACR_T1_PB7]), // R16
    .ovr_val_i(s_q.t1_pb7),
    .pins_i(port_b_lines_i),
    .pins_o(port_b_lines_o),
    .pins_oe_o(port_b_lines_oe_o)
  );

  // ****************************************
  // Read multiplexer
  // ****************************************
  always_comb begin
    unique case (rs) // R8
      `VIB_REG_PB: rmux = pb_rdata; // R21
      `VIB_REG_PA: rmux = pa_rdata;
      `VIB_REG_DIRB: rmux = pb_dir;
      `VIB_REG_DIRA: rmux = pa_dir;
      `VIB_REG_T1CL: rmux = s_q.t1_cnt[`VIB_DW-1:0];
      `VIB_REG_T1CH: rmux = s_q.t1_cnt[`VIB_TW-1:`VIB_DW];
      `VIB_REG_T1LL: rmux = s_q.t1_lat[`VIB_DW-1:0];
      `VIB_REG_T1LH: rmux = s_q.t1_lat[`VIB_TW-1:`VIB_DW];
      `VIB_REG_T2CL: rmux = s_q.t2_cnt[`VIB_DW-1:0];
      `VIB_REG_T2CH: rmux = s_q.t2_cnt[`VIB_TW-1:`VIB_DW];
      `VIB_REG_SR: rmux = s_q.sr;
      `VIB_REG_ACR: rmux = s_q.auxiliary_control;
      `VIB_REG_PCR: rmux = s_q.control_line_config;
      `VIB_REG_IFR: rmux = {irq_any, s_q.interrupt_flags};
      `VIB_REG_IER: rmux = {1'b1, s_q.interrupt_enables};
      `VIB_REG_PA_NH: rmux = pa_rdata;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    f_set = '0;
    f_clr = '0;
    s_d.phi2_p = phi2_i;
    s_d.ca1_p = port_a_control_one_i;
    s_d.ca2_p = port_a_control_two_i;
    s_d.cb1_p = port_b_control_one_i;
    s_d.cb2_p = port_b_control_two_i;
    s_d.pb6_p = port_b_lines_i[`VIB_PB_CNT];

    // Bus read data; released when unselected or phase two is low.
    s_d.data = rmux; // R4
    s_d.data_oe = sel & bus_i.rw & phi2_i & ~pin_rst; // R5 R22

    // Control line flags.
    f_set[`VIB_IF_CA1] = ca1_edge; // R15
    f_set[`VIB_IF_CB1] = cb1_edge; // R15
    f_set[`VIB_IF_CA2] = ca2_edge & ~ca2_mode[`VIB_CL_OUT]; // R15
    f_set[`VIB_IF_CB2] = cb2_edge & ~cb2_mode[`VIB_CL_OUT]; // R15
    if (rd && rs == `VIB_REG_PA) begin // R8
      f_clr[`VIB_IF_CA1] = 1'b1;
      f_clr[`VIB_IF_CA2] = 1'b1;
    end
    if ((rd || wr) && rs == `VIB_REG_PB) begin
      f_clr[`VIB_IF_CB1] = 1'b1;
      f_clr[`VIB_IF_CB2] = 1'b1;
    end

    // Second control lines.
    s_d.ca2_oe = ca2_mode[`VIB_CL_OUT];
    s_d.cb2_oe = cb2_mode[`VIB_CL_OUT];
    unique case (ca2_mode)
      `VIB_CL_HANDSHAKE: begin
        if (ca1_edge) begin
          s_d.ca2 = 1'b1;
        end else if (rd && rs == `VIB_REG_PA) begin
          s_d.ca2 = 1'b0;
        end
      end
      `VIB_CL_PULSE: begin
        // Low for one phase-two cycle after the read, restored at the next fall.
        if (rd && rs == `VIB_REG_PA) begin // R20
          s_d.ca2 = 1'b0;
        end else if (tick) begin
          s_d.ca2 = 1'b1;
        end
      end
      `VIB_CL_LOW: s_d.ca2 = 1'b0;
      `VIB_CL_HIGH: s_d.ca2 = 1'b1;
      default: s_d.ca2 = 1'b1;
    endcase
    unique case (cb2_mode)
      `VIB_CL_HANDSHAKE: begin
        if (cb1_edge) begin
          s_d.cb2 = 1'b1;
        end else if (wr && rs == `VIB_REG_PB) begin
          s_d.cb2 = 1'b0;
        end
      end
      `VIB_CL_PULSE: begin
        if (wr && rs == `VIB_REG_PB) begin
          s_d.cb2 = 1'b0;
        end else if (tick) begin
          s_d.cb2 = 1'b1;
        end
      end
      `VIB_CL_LOW: s_d.cb2 = 1'b0;
      `VIB_CL_HIGH: s_d.cb2 = 1'b1;
      default: s_d.cb2 = 1'b1;
    endcase

    // Timer one counts phase-two cycles.
    if (tick && !pin_rst) begin // R3
      if (s_q.t1_cnt == `VIB_ZERO16) begin
        if (s_q.t1_armed || s_q.auxiliary_control[`VIB_ACR_T1_FREE]) begin
          f_set[`VIB_IF_T1] = 1'b1;
        end
        if (s_q.auxiliary_control[`VIB_ACR_T1_FREE]) begin
          s_d.t1_cnt = s_q.t1_lat;
          s_d.t1_pb7 = ~s_q.t1_pb7; // R16
        end else begin
          s_d.t1_cnt = s_q.t1_cnt - `VIB_ONE16;
          s_d.t1_pb7 = 1'b1; // R16
          s_d.t1_armed = 1'b0;
        end
      end else begin
        s_d.t1_cnt = s_q.t1_cnt - `VIB_ONE16;
      end
    end

    // Timer two counts phase-two cycles or falling edges on port B bit 6.
    if (!pin_rst && (s_q.auxiliary_control[`VIB_ACR_T2_COUNT] ? pb6_fall : tick)) begin // R16 R3
      if (s_q.t2_cnt == `VIB_ZERO16 && s_q.t2_armed) begin
        f_set[`VIB_IF_T2] = 1'b1;
        s_d.t2_armed = 1'b0;
      end
      s_d.t2_cnt = s_q.t2_cnt - `VIB_ONE16;
    end

    // Shift register on the external serial clock and data lines.
    if (s_q.sh_st == VIB_SH_RUN && !pin_rst) begin // R17 R3
      if ((sr_mode == `VIB_SR_IN_EXT && cb1_rise) || (sr_mode == `VIB_SR_OUT_EXT && cb1_fall)) begin
        s_d.sr = {s_q.sr[`VIB_DW-2:0],
                  (sr_mode == `VIB_SR_IN_EXT) ? port_b_control_two_i : s_q.sr[`VIB_DW-1]};
        s_d.sh_cnt = s_q.sh_cnt + `VIB_SH_ONE;
        if (s_q.sh_cnt == `VIB_SH_LAST) begin
          f_set[`VIB_IF_SR] = 1'b1;
          s_d.sh_st = VIB_SH_IDLE;
        end
      end
    end
    if (sr_mode == `VIB_SR_OUT_EXT) begin // R17
      s_d.cb2_oe = 1'b1;
      s_d.cb2 = s_d.sr[`VIB_DW-1];
    end

    // Register writes and read side effects.
    if (rd && rs == `VIB_REG_T1CL) begin
      f_clr[`VIB_IF_T1] = 1'b1;
    end
    if (rd && rs == `VIB_REG_T2CL) begin
      f_clr[`VIB_IF_T2] = 1'b1;
    end
    if ((rd || wr) && rs == `VIB_REG_SR) begin
      f_clr[`VIB_IF_SR] = 1'b1;
      s_d.sh_st = VIB_SH_RUN;
      s_d.sh_cnt = `VIB_SH_ZERO;
    end
    if (wr) begin // R8
      unique case (rs)
        `VIB_REG_T1CL, `VIB_REG_T1LL: s_d.t1_lat[`VIB_DW-1:0] = wd;
        `VIB_REG_T1CH: begin
          s_d.t1_lat[`VIB_TW-1:`VIB_DW] = wd;
          s_d.t1_cnt = {wd, s_q.t1_lat[`VIB_DW-1:0]};
          s_d.t1_armed = 1'b1;
          s_d.t1_pb7 = 1'b0;
          f_clr[`VIB_IF_T1] = 1'b1;
        end
        `VIB_REG_T1LH: begin
          s_d.t1_lat[`VIB_TW-1:`VIB_DW] = wd;
          f_clr[`VIB_IF_T1] = 1'b1;
        end
        `VIB_REG_T2CL: s_d.t2_lat_lo = wd;
        `VIB_REG_T2CH: begin
          s_d.t2_cnt = {wd, s_q.t2_lat_lo};
          s_d.t2_armed = 1'b1;
          f_clr[`VIB_IF_T2] = 1'b1;
        end
        `VIB_REG_SR: s_d.sr = wd;
        `VIB_REG_ACR: s_d.auxiliary_control = wd;
        `VIB_REG_PCR: s_d.control_line_config = wd;
        `VIB_REG_IFR: f_clr = f_clr | wd[`VIB_FLAGS-1:0];
        `VIB_REG_IER: begin
          if (wd[`VIB_IER_SET]) begin
            s_d.interrupt_enables = s_q.interrupt_enables | wd[`VIB_FLAGS-1:0];
          end else begin
            s_d.interrupt_enables = s_q.interrupt_enables & ~wd[`VIB_FLAGS-1:0];
          end
        end
        default: s_d.auxiliary_control = s_d.auxiliary_control;
      endcase
    end

    // A new event outranks a clear in the same cycle.
    s_d.interrupt_flags = (s_q.interrupt_flags & ~f_clr) | f_set;
    s_d.irq_oe = |(s_d.interrupt_flags & s_d.interrupt_enables); // R9 R10

    // The reset pin leaves timer counts, latches and the shift register alone.
    if (pin_rst) begin // R1 R3
      s_d.auxiliary_control = `VIB_ZERO8;
      s_d.control_line_config = `VIB_ZERO8;
      s_d.interrupt_flags = '0;
      s_d.interrupt_enables = '0;
      s_d.irq_oe = 1'b0;
      s_d.t1_armed = 1'b0;
      s_d.t1_pb7 = 1'b0;
      s_d.t2_armed = 1'b0;
      s_d.sh_st = VIB_SH_IDLE;
      s_d.sh_cnt = `VIB_SH_ZERO;
      s_d.ca2 = 1'b0;
      s_d.cb2 = 1'b0;
      s_d.ca2_oe = 1'b0; // R2
      s_d.cb2_oe = 1'b0; // R2
      s_d.data_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign data_o = s_q.data;
  assign data_oe_o = s_q.data_oe;
  // The interrupt pin only ever pulls low; its drive level is a constant zero.
  assign irq_o = 1'b0; // R10
  assign irq_oe_o = s_q.irq_oe; // R9
  assign port_a_control_two_o = s_q.ca2;
  assign port_a_control_two_oe_o = s_q.ca2_oe;
  assign port_b_control_two_o = s_q.cb2;
  assign port_b_control_two_oe_o = s_q.cb2_oe;

endmodule : vib_top

// ==== src/vib_cfg.svh ====
// Named constants for the interface adapter: register numbers, field positions, modes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef VIB_CFG_SVH
`define VIB_CFG_SVH

// ****************************************
// Widths
// ****************************************
`define VIB_DW 8
`define VIB_TW 16
`define VIB_FLAGS 7
`define VIB_SH_CW 4

// ****************************************
// Register numbers
// ****************************************
`define VIB_REG_PB 4'h0
`define VIB_REG_PA 4'h1
`define VIB_REG_DIRB 4'h2
`define VIB_REG_DIRA 4'h3
`define VIB_REG_T1CL 4'h4
`define VIB_REG_T1CH 4'h5
`define VIB_REG_T1LL 4'h6
`define VIB_REG_T1LH 4'h7
`define VIB_REG_T2CL 4'h8
`define VIB_REG_T2CH 4'h9
`define VIB_REG_SR 4'hA
`define VIB_REG_ACR 4'hB
`define VIB_REG_PCR 4'hC
`define VIB_REG_IFR 4'hD
`define VIB_REG_IER 4'hE
`define VIB_REG_PA_NH 4'hF

// ****************************************
// Interrupt flag bit positions
// ****************************************
`define VIB_IF_CA2 0
`define VIB_IF_CA1 1
`define VIB_IF_SR 2
`define VIB_IF_CB2 3
`define VIB_IF_CB1 4
`define VIB_IF_T2 5
`define VIB_IF_T1 6
`define VIB_IF_ANY 7
`define VIB_IER_SET 7

// ****************************************
// Auxiliary control fields
// ****************************************
`define VIB_ACR_PA_LATCH 0
`define VIB_ACR_PB_LATCH 1
`define VIB_ACR_SR_LO 2
`define VIB_ACR_SR_HI 4
`define VIB_ACR_T2_COUNT 5
`define VIB_ACR_T1_FREE 6
`define VIB_ACR_T1_PB7 7
`define VIB_SR_IN_EXT 3'h3
`define VIB_SR_OUT_EXT 3'h7

// ****************************************
// Control line configuration fields and the port B counting bit
// ****************************************
`define VIB_PCR_CA1_POS 0
`define VIB_PCR_CA2_LO 1
`define VIB_PCR_CA2_HI 3
`define VIB_PCR_CB1_POS 4
`define VIB_PCR_CB2_LO 5
`define VIB_PCR_CB2_HI 7
`define VIB_CL_HANDSHAKE 3'h4
`define VIB_CL_PULSE 3'h5
`define VIB_CL_LOW 3'h6
`define VIB_CL_HIGH 3'h7
`define VIB_CL_OUT 2
`define VIB_PB_CNT 6

// ****************************************
// Reset values and steps
// ****************************************
`define VIB_ZERO8 8'h00
`define VIB_ZERO16 16'h0000
`define VIB_ONE16 16'h0001
`define VIB_SH_ZERO 4'h0
`define VIB_SH_ONE 4'h1
`define VIB_SH_LAST 4'h7

`endif

// ==== src/vib_pkg.sv ====
// Types shared by the interface adapter modules.
// Assumes vib_cfg.svh is on the include path.
`include "vib_cfg.svh"

package vib_pkg;

  typedef struct packed {
    logic sel_high;
    logic sel_low_n;
    logic rw;
    logic [3:0] register_select;
    logic [`VIB_DW-1:0] wdata;
  } vib_bus_t;

  typedef enum logic {
    VIB_SH_IDLE,
    VIB_SH_RUN
  } vib_shift_st_t;

  typedef struct packed {
    logic [`VIB_DW-1:0] dir;
    logic [`VIB_DW-1:0] outv;
    logic [`VIB_DW-1:0] latched;
    logic held;
    logic [`VIB_DW-1:0] pin_o;
    logic [`VIB_DW-1:0] pin_oe;
  } vib_port_st_t;

  typedef struct packed {
    logic phi2_p;
    logic ca1_p;
    logic ca2_p;
    logic cb1_p;
    logic cb2_p;
    logic pb6_p;
    logic [`VIB_DW-1:0] data;
    logic data_oe;
    logic irq_oe;
    logic [`VIB_TW-1:0] t1_cnt;
    logic [`VIB_TW-1:0] t1_lat;
    logic t1_armed;
    logic t1_pb7;
    logic [`VIB_TW-1:0] t2_cnt;
    logic [`VIB_DW-1:0] t2_lat_lo;
    logic t2_armed;
    logic [`VIB_DW-1:0] sr;
    logic [`VIB_SH_CW-1:0] sh_cnt;
    vib_shift_st_t sh_st;
    logic [`VIB_DW-1:0] auxiliary_control;
    logic [`VIB_DW-1:0] control_line_config;
    logic [`VIB_FLAGS-1:0] interrupt_flags;
    logic [`VIB_FLAGS-1:0] interrupt_enables;
    logic ca2;
    logic cb2;
    logic ca2_oe;
    logic cb2_oe;
  } vib_state_t;

endpackage : vib_pkg

// ==== src/vib_port.sv ====
// One peripheral port: direction, output value, input latch and readback.
// Assumes pins are synchronous to clk_i and strobes are one-cycle pulses.
`timescale 1ns/10ps
`include "vib_cfg.svh"

module vib_port
  import vib_pkg::*;
#(
  parameter int W = `VIB_DW,
  parameter bit OUT_READBACK = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  // Register access
  input wire logic wr_data_i,
  input wire logic wr_dir_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic read_ack_i,
  output logic [W-1:0] rdata_o,
  output logic [W-1:0] dir_o,
  // Latch and top-line override
  input wire logic latch_en_i,
  input wire logic latch_stb_i,
  input wire logic ovr_en_i,
  input wire logic ovr_val_i,
  // Pins
  input wire logic [W-1:0] pins_i,
  output logic [W-1:0] pins_o,
  output logic [W-1:0] pins_oe_o
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (W != `VIB_DW) begin : g_bad_width
    $error("vib_port width must equal the register width");
  end

  vib_port_st_t s_q;
  vib_port_st_t s_d;
  logic [W-1:0] src;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (wr_data_i) begin
      s_d.outv = wdata_i;
    end
    if (wr_dir_i) begin
      s_d.dir = wdata_i;
    end
    if (read_ack_i) begin
      s_d.held = 1'b0;
    end
    // A latching edge in the same cycle as the read keeps the new sample.
    if (latch_stb_i && latch_en_i) begin // R14
      s_d.latched = pins_i;
      s_d.held = 1'b1;
    end
    s_d.pin_oe = s_d.dir; // R11
    s_d.pin_o = s_d.outv; // R12
    if (ovr_en_i) begin // R16
      s_d.pin_oe[W-1] = 1'b1;
      s_d.pin_o[W-1] = ovr_val_i;
    end
    if (clr_i) begin // R1
      s_d.dir = '0;
      s_d.outv = '0;
      s_d.held = 1'b0;
      s_d.pin_oe = '0; // R2
      s_d.pin_o = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Readback
  // ****************************************
  assign src = s_q.held ? s_q.latched : pins_i;
  assign rdata_o = OUT_READBACK ? ((s_q.dir & s_q.outv) | (~s_q.dir & src)) : src; // R21
  assign dir_o = s_q.dir;
  // Lines set as inputs are released unless the top-line override drives them, so stored bits never reach them.
  assign pins_o = s_q.pin_o; // R13
  assign pins_oe_o = s_q.pin_oe;

endmodule : vib_port

// ==== bench/vib_periph.sv ====
// Peripheral model for both ports; drives lines the adapter leaves as inputs.
// Assumes the adapter's line outputs are registered on the same clock.
`timescale 1ns/10ps

module vib_periph (
  // Adapter side
  input wire logic [7:0] a_o_i,
  input wire logic [7:0] a_oe_i,
  input wire logic [7:0] b_o_i,
  input wire logic [7:0] b_oe_i,
  // Peripheral side
  input wire logic [7:0] a_ext_i,
  input wire logic [7:0] b_ext_i,
  input wire logic [7:0] b_load_i,
  output logic [7:0] a_pin_o,
  output logic [7:0] b_pin_o
);
  // A heavy load may pull a driven port B line away from its stored level.
  assign a_pin_o = (a_o_i & a_oe_i) | (a_ext_i & ~a_oe_i);
  assign b_pin_o = (b_o_i & b_oe_i & ~b_load_i) | (b_ext_i & (~b_oe_i | b_load_i));
endmodule : vib_periph

// ==== bench/vib_top_chk.sv ====
// Port-level checker for the adapter top.
// Assumes vib_cfg.svh on the include path; bound into vib_top.
`timescale 1ns/10ps
`include "vib_cfg.svh"

module vib_top_chk
  import vib_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reset_in_n_i,
  input wire logic phi2_i,
  input wire vib_bus_t bus_i,
  input wire logic data_oe_o,
  input wire logic irq_o,
  input wire logic irq_oe_o,
  input wire logic [`VIB_DW-1:0] port_a_lines_o,
  input wire logic [`VIB_DW-1:0] port_a_lines_oe_o,
  input wire logic [`VIB_DW-1:0] port_b_lines_oe_o,
  input wire logic port_a_control_two_oe_o,
  input wire logic port_b_control_two_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic sel = bus_i.sel_high & ~bus_i.sel_low_n;
  dir_off_a: assert property (!reset_in_n_i |=>
    port_a_lines_oe_o == 8'h00 && port_b_lines_oe_o == 8'h00) else $error("line driven in reset");
  irq_rst_a: assert property (!reset_in_n_i |=> !irq_oe_o)
    else $error("irq active in reset");
  ctl_rst_a: assert property (!reset_in_n_i |=>
    !port_a_control_two_oe_o && !port_b_control_two_oe_o) else $error("control line driven");
  bus_release_a: assert property (!sel |=> !data_oe_o)
    else $error("data driven while unselected");
  read_drive_a: assert property (sel && bus_i.rw && phi2_i && reset_in_n_i |=> data_oe_o)
    else $error("read not driven");
  write_quiet_a: assert property (sel && !bus_i.rw |=> !data_oe_o)
    else $error("data driven on write");
  irq_level_a: assert property (irq_o == 1'b0)
    else $error("irq drives high");
  pin_hold_a: assert property ((reset_in_n_i && $stable(phi2_i)) [*4] |=>
    $stable(port_a_lines_oe_o) && $stable(port_a_lines_o)) else $error("port A moved idle");
endmodule : vib_top_chk

bind vib_top vib_top_chk i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .reset_in_n_i(reset_in_n_i), .phi2_i(phi2_i), .bus_i(bus_i), .data_oe_o(data_oe_o),
  .irq_o(irq_o), .irq_oe_o(irq_oe_o), .port_a_lines_o(port_a_lines_o),
  .port_a_lines_oe_o(port_a_lines_oe_o), .port_b_lines_oe_o(port_b_lines_oe_o),
  .port_a_control_two_oe_o(port_a_control_two_oe_o),
  .port_b_control_two_oe_o(port_b_control_two_oe_o));

// ==== bench/versatile_interface_bus_and_ports_tb.sv ====
// Self-checking bench for the adapter: register map, ports, flags, reset pin.
// Assumes vib_top, vib_periph and the bound checker are compiled first.
`timescale 1ns/10ps

module versatile_interface_bus_and_ports_tb;
  import vib_pkg::*;
  typedef struct packed {
    logic [3:0] rs;
    logic [7:0] wd;
    logic [7:0] exp;
  } vib_row_t;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic rst_n = 1'b0;
  logic phi2 = 1'b0;
  logic ca1 = 1'b0;
  logic cb1 = 1'b0;
  logic [7:0] b_ext = 8'hC3;
  vib_bus_t bus = '{1'b0, 1'b1, 1'b1, 4'h0, 8'h00};
  logic [7:0] a_ext = 8'h3C;
  logic [7:0] b_load = 8'hFF;
  logic [7:0] d_o, a_o, a_oe, b_o, b_oe, a_pin, b_pin, rd;
  logic d_oe, irq, irq_oe, ca2_o, ca2_oe, cb2_o, cb2_oe;
  int n_errors = 0;
  int num_checks = 0;
  // Port B is loaded, so reads of output lines must come from the stored value.
  vib_row_t rows [7] = '{'{4'h2, 8'hFF, 8'hFF}, '{4'h3, 8'h0F, 8'h0F}, '{4'hB, 8'h01, 8'h01},
    '{4'hC, 8'hEF, 8'hEF}, '{4'hE, 8'h9B, 8'h9B}, '{4'h1, 8'hA5, 8'h35}, '{4'h0, 8'h5A, 8'h5A}};

  vib_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reset_in_n_i(rst_n), .phi2_i(phi2),
    .bus_i(bus), .data_o(d_o), .data_oe_o(d_oe), .irq_o(irq), .irq_oe_o(irq_oe),
    .port_a_lines_i(a_pin), .port_a_lines_o(a_o), .port_a_lines_oe_o(a_oe),
    .port_a_control_one_i(ca1), .port_a_control_two_i(ca2_o | ~ca2_oe),
    .port_a_control_two_o(ca2_o), .port_a_control_two_oe_o(ca2_oe),
    .port_b_lines_i(b_pin), .port_b_lines_o(b_o), .port_b_lines_oe_o(b_oe),
    .port_b_control_one_i(cb1), .port_b_control_two_i(cb2_o | ~cb2_oe),
    .port_b_control_two_o(cb2_o), .port_b_control_two_oe_o(cb2_oe));
  vib_periph i_periph (.a_o_i(a_o), .a_oe_i(a_oe), .b_o_i(b_o), .b_oe_i(b_oe),
    .a_ext_i(a_ext), .b_ext_i(b_ext), .b_load_i(b_load), .a_pin_o(a_pin), .b_pin_o(b_pin));

  always #5 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic acc(input logic s, input logic rw, input logic [3:0] rs, input logic [7:0] wd);
    @(posedge clk_i);
    phi2 <= 1'b1;
    bus <= '{s, 1'b0, rw, rs, wd};
    @(posedge clk_i);
    phi2 <= 1'b0;
    #1 rd = d_o;
    chk("drive", {7'h00, s & rw}, {7'h00, d_oe});
    @(posedge clk_i);
    bus <= '{1'b0, 1'b1, 1'b1, 4'h0, 8'h00};
  endtask : acc

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      acc(1'b1, 1'b0, rows[i].rs, rows[i].wd);
      acc(1'b1, 1'b1, rows[i].rs, 8'h00);
      chk("readback", rows[i].exp, rd);
    end
    chk("b_out", 8'h5A, b_o);
    acc(1'b1, 1'b0, 4'hB, 8'h2D);
    acc(1'b1, 1'b0, 4'h8, 8'h01);
    acc(1'b1, 1'b0, 4'h9, 8'h00);
    acc(1'b1, 1'b0, 4'hA, 8'h00);
    repeat (8) begin
      b_ext <= 8'h83;
      cb1 <= 1'b1;
      repeat (2) @(posedge clk_i);
      b_ext <= 8'hC3;
      cb1 <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    acc(1'b1, 1'b1, 4'hD, 8'h00);
    chk("t2_sr_flags", 8'hB4, rd);
    acc(1'b1, 1'b1, 4'hA, 8'h00);
    chk("shift_in", 8'hFF, rd);
    acc(1'b1, 1'b0, 4'hD, 8'h30);
    acc(1'b0, 1'b1, 4'h3, 8'h00);
    chk("a_oe", 8'h0F, a_oe);
    chk("a_out", 8'h05, a_o & a_oe);
    acc(1'b1, 1'b0, 4'h1, 8'hFF);
    repeat (3) @(posedge clk_i);
    chk("a_masked", 8'h3F, a_pin);
    ca1 <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("irq", 8'h01, {7'h00, irq_oe});
    a_ext <= 8'hF0;
    acc(1'b1, 1'b1, 4'hF, 8'h00);
    chk("latched", 8'h3F, rd);
    acc(1'b1, 1'b1, 4'hD, 8'h00);
    chk("flags", 8'h82, rd);
    acc(1'b1, 1'b1, 4'h1, 8'h00);
    chk("released", 8'hFF, rd);
    repeat (2) @(posedge clk_i);
    chk("irq_clr", 8'h00, {7'h00, irq_oe});
    acc(1'b1, 1'b0, 4'hC, 8'h0B);
    acc(1'b1, 1'b1, 4'h1, 8'h00);
    chk("transparent", 8'hFF, rd);
    repeat (2) @(posedge clk_i);
    chk("pulse_low", 8'h02, {6'h00, ca2_oe, ca2_o});
    acc(1'b1, 1'b1, 4'hF, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("pulse_end", 8'h03, {6'h00, ca2_oe, ca2_o});
    ca1 <= 1'b0;
    @(posedge clk_i);
    ca1 <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("rst_oe", 8'h00, a_oe | b_oe);
    chk("rst_irq", 8'h00, {7'h00, irq_oe});
    rst_n <= 1'b1;
    acc(1'b1, 1'b1, 4'h3, 8'h00);
    chk("rst_dir", 8'h00, rd);
    acc(1'b1, 1'b1, 4'hE, 8'h00);
    chk("rst_ier", 8'h80, rd);
    final_report();
  end
endmodule : versatile_interface_bus_and_ports_tb
